// >>> rtl/interrupt_priority_resolver.sv
`timescale 1ns/100ps

module interrupt_priority_resolver
  import irq_prio_pkg::*;
(
  input  wire logic                    REF_CLK_IN,
  input  wire logic                    ARST_N_IN,
  input  wire logic [15:0]             AVS_ADDRESS_IN,
  input  wire logic                    AVS_READ_IN,
  input  wire logic                    AVS_WRITE_IN,
  input  wire logic [31:0]             AVS_WRITEDATA_IN,
  input  wire logic [3:0]              AVS_BYTEENABLE_IN,
  output logic      [31:0]             AVS_READDATA_OUT,
  output logic                         AVS_WAITREQUEST_OUT,
  input  wire logic                    MODE_PIN_A_IN,
  input  wire logic                    MODE_PIN_B_IN,
  input  wire logic                    IMASK_IN,
  input  wire logic                    XMASK_IN,
  input  wire nonmask_req_t            NONMASK_REQ_IN,
  input  wire logic [NUM_MASKABLE-1:0] MASK_REQ_IN,
  input  wire logic [NUM_MASKABLE-1:0] LOCAL_EN_IN,
  output vec_ans_t                     VEC_ANS_OUT,
  output logic                         READ_VISIBLE_OUT,
  output logic                         BUS_CLK_OUT_EN_OUT
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Release is delayed two edges so all state leaves reset together
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Code to promoted maskable index; reserved code folds onto external pin
  function automatic logic [3:0] sel_to_src(input logic [3:0] code);
    logic [3:0] src;
    src = SRC_EXT;
    case (code)
      4'h0:    src = SRC_TOF;
      4'h1:    src = SRC_PAOV;
      4'h2:    src = SRC_PAEDG;
      4'h3:    src = SRC_SPI;
      4'h4:    src = SRC_SCI;
      4'h5:    src = SRC_EXT;
      4'h6:    src = SRC_EXT;
      4'h7:    src = SRC_RTI;
      default: src = code - 4'h6;
    endcase
    return src;
  endfunction

  // Fixed vector per maskable source, independent of ranking
  function automatic logic [15:0] mask_vec(input logic [3:0] src);
    logic [15:0] v;
    v = VEC_IC1 - ({12'h000, src} - 16'h0002) * VEC_STEP;
    if (src == SRC_EXT)
      v = VEC_EXT;
    else if (src == SRC_RTI)
      v = VEC_RTI;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Mode capture and register state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAP_WAIT = 2'b01,
    CAP_DONE = 2'b10
  } cap_state_t;

  cap_state_t cap_ff;
  cap_state_t nxt_cap;
  logic       boot_rom_read_ff;
  logic       special_mode_flag_ff;
  logic       mode_a_latch_ff;
  logic       read_vis_ff;
  logic [3:0] prio_sel_ff;
  logic       ack_ff;
  logic [7:0] rd_byte_ff;
  logic       nxt_boot_rom_read;
  logic       nxt_special_mode_flag;
  logic       nxt_mode_a_latch;
  logic       nxt_read_vis;
  logic [3:0] nxt_prio_sel;
  logic       nxt_ack;
  logic [7:0] nxt_rd_byte;
  logic       hit;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] reg_view;

  // Reads sample the register on the request cycle; writes commit only on
  // the accepting edge, so a master still held in wait changes nothing
  assign hit      = (AVS_ADDRESS_IN[15:2] == PRIO_MISC_OFFSET[15:2]);
  assign wr_go    = AVS_WRITE_IN && ack_ff && AVS_BYTEENABLE_IN[0];
  assign rd_go    = AVS_READ_IN && !ack_ff;
  assign reg_view = {boot_rom_read_ff & special_mode_flag_ff, special_mode_flag_ff,
                     mode_a_latch_ff, read_vis_ff, prio_sel_ff};

  // Next register values; mode pins caught on first cycle after release
  always_comb
  begin
    nxt_cap               = cap_ff;
    nxt_boot_rom_read     = boot_rom_read_ff;
    nxt_special_mode_flag = special_mode_flag_ff;
    nxt_mode_a_latch      = mode_a_latch_ff;
    nxt_read_vis          = read_vis_ff;
    nxt_prio_sel          = prio_sel_ff;
    nxt_ack               = (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
    nxt_rd_byte           = 8'h00;
    case (cap_ff)
      CAP_WAIT:
      begin
        nxt_special_mode_flag = ~MODE_PIN_B_IN;
        nxt_mode_a_latch      = MODE_PIN_A_IN;
        nxt_boot_rom_read     = ~MODE_PIN_B_IN & ~MODE_PIN_A_IN;
        nxt_read_vis          = ~MODE_PIN_B_IN & MODE_PIN_A_IN;
        nxt_cap               = CAP_DONE;
        nxt_ack               = 1'b0;
      end
      CAP_DONE:
      begin
        if (hit && rd_go)
          nxt_rd_byte = reg_view;
        if (hit && wr_go)
        begin
          if (special_mode_flag_ff)
            nxt_boot_rom_read = AVS_WRITEDATA_IN[BOOT_BIT];
          nxt_read_vis = AVS_WRITEDATA_IN[RDVIS_BIT];
          if (IMASK_IN)
            nxt_prio_sel = AVS_WRITEDATA_IN[3:0];
        end
      end
      default: nxt_cap = CAP_WAIT;
    endcase
  end

  // Register update; the select field comes out of reset at SEL_RESET
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      cap_ff               <= CAP_WAIT;
      boot_rom_read_ff     <= 1'b0;
      special_mode_flag_ff <= 1'b0;
      mode_a_latch_ff      <= 1'b0;
      read_vis_ff          <= 1'b0;
      prio_sel_ff          <= SEL_RESET;
      ack_ff               <= 1'b0;
      rd_byte_ff           <= 8'h00;
    end
    else
    begin
      cap_ff               <= nxt_cap;
      boot_rom_read_ff     <= nxt_boot_rom_read;
      special_mode_flag_ff <= nxt_special_mode_flag;
      mode_a_latch_ff      <= nxt_mode_a_latch;
      read_vis_ff          <= nxt_read_vis;
      prio_sel_ff          <= nxt_prio_sel;
      ack_ff               <= nxt_ack;
      rd_byte_ff           <= nxt_rd_byte;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // One wait state on every access; unmapped reads return zero
  // Read data stand only in the cycle in which waitrequest is low
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_ff;
  assign AVS_READDATA_OUT    = {24'h000000, rd_byte_ff};

  // ----------------------------------------------------------------
  // Visibility / bus clock control
  // ----------------------------------------------------------------
  // Expanded modes have mode A set; otherwise the bit gates the clock pin
  assign READ_VISIBLE_OUT   = read_vis_ff & mode_a_latch_ff;
  assign BUS_CLK_OUT_EN_OUT = ~read_vis_ff & ~mode_a_latch_ff;

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  logic [NUM_MASKABLE-1:0] live;
  logic [3:0]              prom_src;
  logic [15:0]             prom_vec;
  logic [3:0]              win_src;
  logic                    win_any;
  vec_ans_t                nxt_ans;
  vec_ans_t                ans_ff;

  // Enabled maskable requests, all blocked by the global mask
  assign live     = MASK_REQ_IN & LOCAL_EN_IN & {NUM_MASKABLE{~IMASK_IN}};
  assign prom_src = sel_to_src(prio_sel_ff);
  // Vector of the promoted source, kept as a net for the promotion check
  assign prom_vec = mask_vec(prom_src);

  // Promoted source first, then fixed order scanning from the lowest rank up, so the last live (highest) source wins
  always_comb
  begin
    win_src = 4'h0;
    win_any = 1'b0;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--)
    begin
      if (live[i])
      begin
        win_src = 4'(i);
        win_any = 1'b1;
      end
    end
    if (live[prom_src])
      win_src = prom_src;
  end

  // Non-maskable ladder wins over any maskable request
  always_comb
  begin
    nxt_ans = '{valid: 1'b0, nonmask: 1'b0, vector: VEC_NONE};
    if (NONMASK_REQ_IN.por)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_RESET};
    else if (NONMASK_REQ_IN.clkmon)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_CLKMON};
    else if (NONMASK_REQ_IN.wdog)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_WDOG};
    else if (NONMASK_REQ_IN.nmipin && !XMASK_IN)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_NMIPIN};
    else if (NONMASK_REQ_IN.illop)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_ILLOP};
    else if (NONMASK_REQ_IN.swtrap)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b1, vector: VEC_SWTRAP};
    else if (win_any)
      nxt_ans = '{valid: 1'b1, nonmask: 1'b0, vector: mask_vec(win_src)};
  end

  // Registered vector answer
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
      ans_ff <= '{valid: 1'b0, nonmask: 1'b0, vector: VEC_NONE};
    else
      ans_ff <= nxt_ans;
  end

  assign VEC_ANS_OUT = ans_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!rst_sync_ff);

  sequence sel_write_s;
    hit && wr_go && cap_ff == CAP_DONE;
  endsequence

  sel_guard_a: assert property (sel_write_s ##0 !IMASK_IN |=> $stable(prio_sel_ff))
    else $error("select changed while mask clear");
  sel_load_a: assert property (sel_write_s ##0 IMASK_IN |=>
    prio_sel_ff == $past(AVS_WRITEDATA_IN[3:0]))
    else $error("select write lost");
  mask_block_a: assert property (IMASK_IN && NONMASK_REQ_IN == '0 |=> !ans_ff.valid)
    else $error("maskable served under mask");
  nonmask_win_a: assert property (NONMASK_REQ_IN.por |=>
    ans_ff.vector == VEC_RESET && ans_ff.nonmask)
    else $error("reset vector not chosen");
  promote_win_a: assert property (NONMASK_REQ_IN == '0 && live[prom_src] |=>
    ans_ff.vector == $past(prom_vec))
    else $error("promoted source lost");
  boot_zero_a: assert property (!special_mode_flag_ff |-> !reg_view[BOOT_BIT])
    else $error("boot bit visible outside special mode");
  sel_reset_a: assert property (cap_ff == CAP_WAIT |-> prio_sel_ff == SEL_RESET)
    else $error("select reset value wrong");
  trap_free_a: assert property (NONMASK_REQ_IN == 6'b100000 |=>
    ans_ff.vector == VEC_SWTRAP)
    else $error("trap not served");
  fixed_vec_a: assert property (NONMASK_REQ_IN == '0 && live == 15'h0001 |=>
    ans_ff.vector == VEC_EXT)
    else $error("external vector moved");

  // Mode straps are caught in the single capture cycle after release;
  // a strap that moves later must not disturb the latched mode
  sequence capture_s;
    cap_ff == CAP_WAIT;
  endsequence

  special_mode_flag_cap_a: assert property (capture_s |=>
    special_mode_flag_ff == !$past(MODE_PIN_B_IN))
    else $error("special mode flag not inverse of pin B");
  mda_cap_a: assert property (capture_s |=>
    mode_a_latch_ff == $past(MODE_PIN_A_IN))
    else $error("mode A latch not equal to pin A");
  vis_reset_a: assert property (capture_s |=>
    read_vis_ff == (special_mode_flag_ff && mode_a_latch_ff))
    else $error("visibility reset value wrong");
  boot_lock_a: assert property (sel_write_s ##0 !special_mode_flag_ff |=>
    !boot_rom_read_ff)
    else $error("boot bit written outside special mode");
  reserved_code_a: assert property (prio_sel_ff == SEL_RESERVED |-> prom_src == SRC_EXT)
    else $error("reserved code not folded onto external pin");
  nonmask_first_a: assert property (NONMASK_REQ_IN.por || NONMASK_REQ_IN.clkmon ||
    NONMASK_REQ_IN.wdog |=> ans_ff.nonmask)
    else $error("maskable source beat a non-maskable one");

  // Visibility and clock pin gating follow the latched mode and the visibility bit
  vis_gate_a: assert property (!mode_a_latch_ff |-> !READ_VISIBLE_OUT)
    else $error("read visibility outside expanded modes");
  clk_gate_a: assert property (!mode_a_latch_ff |-> BUS_CLK_OUT_EN_OUT == !read_vis_ff)
    else $error("bus clock pin not following control bit");

endmodule

// >>> rtl/irq_prio_pkg.sv
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] PRIO_MISC_OFFSET = 16'h103C;
  localparam int          BOOT_BIT         = 7;
  localparam int          SPECIAL_MODE_FLAG_BIT         = 6;
  localparam int          MDA_BIT          = 5;
  localparam int          RDVIS_BIT        = 4;
  localparam logic [3:0]  SEL_RESET        = 4'h6;
  localparam logic [3:0]  SEL_RESERVED     = 4'h5;
  localparam int          NUM_MASKABLE     = 15;
  localparam int          NUM_NONMASK      = 6;

  // ----------------------------------------------------------------
  // Maskable source indices, default rank order (0 highest)
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT   = 4'h0;
  localparam logic [3:0] SRC_RTI   = 4'h1;
  localparam logic [3:0] SRC_IC1   = 4'h2;
  localparam logic [3:0] SRC_IC2   = 4'h3;
  localparam logic [3:0] SRC_IC3   = 4'h4;
  localparam logic [3:0] SRC_OC1   = 4'h5;
  localparam logic [3:0] SRC_OC2   = 4'h6;
  localparam logic [3:0] SRC_OC3   = 4'h7;
  localparam logic [3:0] SRC_OC4   = 4'h8;
  localparam logic [3:0] SRC_IC4   = 4'h9;
  localparam logic [3:0] SRC_TOF   = 4'hA;
  localparam logic [3:0] SRC_PAOV  = 4'hB;
  localparam logic [3:0] SRC_PAEDG = 4'hC;
  localparam logic [3:0] SRC_SPI   = 4'hD;
  localparam logic [3:0] SRC_SCI   = 4'hE;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON  = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG    = 16'hFFFA;
  localparam logic [15:0] VEC_ILLOP   = 16'hFFF8;
  localparam logic [15:0] VEC_SWTRAP  = 16'hFFF6;
  localparam logic [15:0] VEC_NMIPIN  = 16'hFFF4;
  localparam logic [15:0] VEC_EXT     = 16'hFFF2;
  localparam logic [15:0] VEC_RTI     = 16'hFFF0;
  localparam logic [15:0] VEC_IC1     = 16'hFFEE;
  localparam logic [15:0] VEC_STEP    = 16'h0002;
  localparam logic [15:0] VEC_SCI     = 16'hFFD6;
  localparam logic [15:0] VEC_NONE    = 16'h0000;

  // Non-maskable sources, bit 0 highest
  typedef struct packed {
    logic swtrap;
    logic illop;
    logic nmipin;
    logic wdog;
    logic clkmon;
    logic por;
  } nonmask_req_t;

  // Resolver answer toward the CPU
  typedef struct packed {
    logic        valid;
    logic        nonmask;
    logic [15:0] vector;
  } vec_ans_t;

endpackage

// >>> verification/cpu_core_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// CPU side: bus master and global mask bits
// ------------------------------------------------------------
module cpu_core_model
(
  input  wire logic        clk_in,
  input  wire logic        wait_in,
  input  wire logic [31:0] rdata_in,
  output logic      [15:0] addr_out,
  output logic             read_out,
  output logic             write_out,
  output logic      [31:0] wdata_out,
  output logic      [3:0]  be_out,
  output logic             imask_out,
  output logic             xmask_out
);
  // Masks start set, as a core leaves reset with interrupts inhibited
  initial
  begin
    {addr_out, read_out, write_out, wdata_out, be_out} = '0;
    imask_out = 1'b1;
    xmask_out = 1'b1;
  end

  // Mask changes land on a rising edge; select writes follow a set mask
  task automatic set_masks(input logic im, input logic xm);
    @(posedge clk_in);
    imask_out <= im;
    xmask_out <= xm;
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus_go(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b,
                        input logic w, output logic [31:0] q);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    be_out    <= b;
    write_out <= w;
    read_out  <= ~w;
    // Sampled on the rising edge; data taken at the accepting edge only
    do @(posedge clk_in); while (wait_in !== 1'b0);
    q = rdata_in;
    read_out  <= 1'b0;
    write_out <= 1'b0;
    // Released address and data lines show a changed value, never the last one; byte enables keep theirs
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps

module tb;
  import irq_prio_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         clk       = 1'b0;
  logic         arst_n    = 1'b0;
  logic         mode_a    = 1'b0;
  logic         mode_b    = 1'b0;
  nonmask_req_t nm        = '0;
  logic [14:0]  req       = '0;
  logic [14:0]  en        = '0;
  logic [15:0]  addr;
  logic         rd, wr, imask, xmask, waitreq, rdvis, clken;
  logic [31:0]  wdata, rdata;
  logic [3:0]   be;
  vec_ans_t     ans;
  logic [7:0]   exp_reg;
  int           err_count = 0;
  int           n_checks  = 0;

  // 10 MHz reference clock
  always #50 clk = ~clk;

  interrupt_priority_resolver interrupt_priority_resolver_i (
    .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .MODE_PIN_A_IN(mode_a),
    .MODE_PIN_B_IN(mode_b), .IMASK_IN(imask), .XMASK_IN(xmask), .NONMASK_REQ_IN(nm),
    .MASK_REQ_IN(req), .LOCAL_EN_IN(en), .VEC_ANS_OUT(ans), .READ_VISIBLE_OUT(rdvis),
    .BUS_CLK_OUT_EN_OUT(clken));

  cpu_core_model cpu_core_model_i (
    .clk_in(clk), .wait_in(waitreq), .rdata_in(rdata), .addr_out(addr), .read_out(rd),
    .write_out(wr), .wdata_out(wdata), .be_out(be), .imask_out(imask), .xmask_out(xmask));

  // ------------------------------------------------------------
  // Expected values
  // ------------------------------------------------------------
  function automatic logic [3:0] lift(input logic [3:0] c);
    return (c < 4'h5) ? c + 4'hA : (c < 4'h7) ? SRC_EXT : (c == 4'h7) ? SRC_RTI : c - 4'h6;
  endfunction

  // Fixed non-maskable order first, then lifted source, then default order
  function automatic vec_ans_t expect_ans(input nonmask_req_t n, input logic [14:0] r,
                                          input logic [14:0] e, input logic im,
                                          input logic xm, input logic [3:0] c);
    logic [14:0] live;
    logic [3:0]  p;
    live = r & e & {15{~im}};
    p = lift(c);
    if (n.por) return '{1'b1, 1'b1, VEC_RESET};
    if (n.clkmon) return '{1'b1, 1'b1, VEC_CLKMON};
    if (n.wdog) return '{1'b1, 1'b1, VEC_WDOG};
    if (n.nmipin && !xm) return '{1'b1, 1'b1, VEC_NMIPIN};
    if (n.illop) return '{1'b1, 1'b1, VEC_ILLOP};
    if (n.swtrap) return '{1'b1, 1'b1, VEC_SWTRAP};
    if (live[p]) return '{1'b1, 1'b0, VEC_EXT - VEC_STEP * {12'h0, p}};
    for (int i = 0; i < 15; i++)
      if (live[i]) return '{1'b1, 1'b0, VEC_EXT - VEC_STEP * 16'(i)};
    return '{1'b0, 1'b0, VEC_NONE};
  endfunction

  // ------------------------------------------------------------
  // Compare, stimulus and closing tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic chk_ans(input vec_ans_t got, input vec_ans_t exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic [3:0] b,
                     input logic w, output logic [31:0] q);
    cpu_core_model_i.bus_go(a, {24'h0, d}, b, w, q);
  endtask

  // Mode straps held through the capture cycle after release
  task automatic do_reset(input logic a, input logic b);
    @(posedge clk);
    mode_a <= a;
    mode_b <= b;
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  // Answer is registered one cycle behind the requests
  task automatic apply(input nonmask_req_t n, input logic [14:0] r, input logic [14:0] e);
    @(posedge clk);
    nm  <= n;
    req <= r;
    en  <= e;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the under one thousand cycles the tests need
  initial
  begin
    #2000000;
    err_count++;
    summarize();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0]  q;
    logic [14:0]  r, e;
    nonmask_req_t n;
    logic         im;
    void'($urandom(32'h85a26238));
    // Every strap combination: reset value, read-only bits, refusals
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m[0], m[1]);
      exp_reg = {~m[1] & ~m[0], ~m[1], m[0], ~m[1] & m[0], SEL_RESET};
      bus(PRIO_MISC_OFFSET, 8'h00, 4'hF, 1'b0, q);
      chk32(q, {24'h0, exp_reg});
      chk32({rdvis, clken}, {exp_reg[4] & m[0], ~exp_reg[4] & ~m[0]});
      cpu_core_model_i.set_masks(1'b0, 1'b0);
      bus(PRIO_MISC_OFFSET, {exp_reg[7:4], 4'h9}, 4'hF, 1'b1, q);
      cpu_core_model_i.set_masks(1'b1, 1'b1);
      bus(16'h1040, {exp_reg[7:4], 4'h1}, 4'hF, 1'b1, q);
      bus(PRIO_MISC_OFFSET, {exp_reg[7:4], 4'h2}, 4'hE, 1'b1, q);
      bus(16'h1040, 8'h00, 4'hF, 1'b0, q);
      chk32(q, 32'h0);
      bus(PRIO_MISC_OFFSET, 8'h00, 4'hF, 1'b0, q);
      chk32(q, {24'h0, exp_reg});
      // Boot bit only sticks in special modes; bits 6 and 5 never change
      bus(PRIO_MISC_OFFSET, {1'b1, ~exp_reg[6:4], 4'h3}, 4'hF, 1'b1, q);
      exp_reg = {exp_reg[6], exp_reg[6:5], ~exp_reg[4], 4'h3};
      bus(PRIO_MISC_OFFSET, 8'h00, 4'hF, 1'b0, q);
      chk32(q, {24'h0, exp_reg});
      chk32({rdvis, clken}, {exp_reg[4] & m[0], ~exp_reg[4] & ~m[0]});
    end
    // Every select code with corner and random request patterns
    for (int c = 0; c < 16; c++)
    begin
      cpu_core_model_i.set_masks(1'b1, 1'b0);
      exp_reg[3:0] = 4'(c);
      bus(PRIO_MISC_OFFSET, exp_reg, 4'hF, 1'b1, q);
      for (int k = 0; k < 12; k++)
      begin
        // Corners: all live, promoted locally off, all masked, external alone, trap over random maskables
        r = (k < 3) ? 15'h7FFF : (k == 3) ? 15'h0001 : 15'($urandom);
        e = (k == 1) ? ~(15'h1 << lift(exp_reg[3:0])) : (k < 4) ? 15'h7FFF : 15'($urandom);
        im = (k == 2) ? 1'b1 : (k < 4) ? 1'b0 : 1'($urandom);
        n = (k < 8) ? nonmask_req_t'(6'h00) : (k == 8) ? nonmask_req_t'(6'h20)
                    : nonmask_req_t'(6'($urandom));
        cpu_core_model_i.set_masks(im, 1'($urandom));
        apply(n, r, e);
        chk_ans(ans, expect_ans(nm, req, en, imask, xmask, exp_reg[3:0]));
      end
    end
    summarize();
  end
endmodule
